// ---- reiu_consts.svh ----
// Constants for the radio event interrupt unit
`ifndef REIU_CONSTS_SVH
`define REIU_CONSTS_SVH

// Property numbers
`define REIU_PROP_GROUP_EN 16'h0100
`define REIU_PROP_PACKET_EN 16'h0101
`define REIU_PROP_MODEM_EN 16'h0102
`define REIU_PROP_CHIP_EN 16'h0103

// Property reset values
`define REIU_GROUP_EN_RST 8'h04
`define REIU_PACKET_EN_RST 8'h00
`define REIU_MODEM_EN_RST 8'h00
`define REIU_CHIP_EN_RST 8'h04

// Group enable bit positions
`define REIU_GRP_PACKET_BIT 0
`define REIU_GRP_MODEM_BIT 1
`define REIU_GRP_CHIP_BIT 2

// Chip event bit raised by a radio state change
`define REIU_CHIP_STATE_BIT 4

// Command codes
`define REIU_CMD_ALL 8'h20
`define REIU_CMD_PACKET 8'h21
`define REIU_CMD_MODEM 8'h22
`define REIU_CMD_CHIP 8'h23

// Response lengths in bytes
`define REIU_LEN_ALL 3'd6
`define REIU_LEN_GROUP 3'd2

// Fast reply selectors
`define REIU_FRR_PACKET 2'h0
`define REIU_FRR_MODEM 2'h1
`define REIU_FRR_CHIP 2'h2
`define REIU_FRR_STATE 2'h3

// Timing
`define REIU_CLK_PERIOD_NS 40
`define REIU_FRR_DELAY_NS 5000
`define REIU_IRQ_DELAY_NS 13000

`endif

// ---- reiu_pkg.sv ----
// Types of the radio event interrupt unit
package reiu_pkg;

  typedef enum logic [0:0] {
    REIU_IDLE = 1'b0,
    REIU_SEND = 1'b1
  } reiu_state_type;

  typedef logic [7:0] reiu_byte_type;

endpackage : reiu_pkg

// ---- reiu_event_group.sv ----
// Sticky pending-event latch for one event group
`timescale 1ns/1ns
module reiu_event_group #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Events and clear mask
  input wire logic [WIDTH-1:0] set_i,
  input wire logic [WIDTH-1:0] clr_i,
  // Pending state
  output logic [WIDTH-1:0] pend_o
);

  // A set in the clearing cycle survives the clear
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pend_o <= '0;
    end else begin
      pend_o <= (pend_o & ~clr_i) | set_i;
    end
  end

endmodule : reiu_event_group

// ---- radio_event_interrupt_unit.sv ----
// Event collection, status commands and interrupt pin of the radio
// Function
// RULE1 - The interrupt pin is driven low when any enabled event becomes pending.
// RULE2 - Once low, the pin stays low until a status command reads the events, then stays high until a new event.
// RULE3 - Events form packet, modem and chip groups, each with its own enable byte at properties 0101 to 0103.
// RULE4 - An event reaches the pin only when both its own enable and its group enable in property 0100 are set.
// RULE5 - After reset the group and chip enable bytes hold 0x04 and the packet and modem enable bytes hold 0x00.
// RULE6 - Command 0x20 returns pending events of all groups and by default clears all returned events.
// RULE7 - Commands 0x21, 0x22 and 0x23 return and clear only their own group and leave the others alone.
// RULE8 - Each status reply carries the live status bytes after the pending-event bytes.
// RULE9 - Live status bits show the present condition whatever the enables say.
// RULE10 - Fast reply reads show group events but never clear them or release the pin.
// RULE11 - The host must use status commands, not fast reply reads, to release the pin.
// RULE12 - After entering a new radio state the fast reply state updates after 5 us and the pin after 13 us.
// RULE13 - An event arriving while its group is read and cleared stays pending and reasserts the pin.
`timescale 1ns/1ns
`include "reiu_consts.svh"
module radio_event_interrupt_unit #(
  parameter int STATE_WIDTH = 4
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Property access
  input wire logic prop_wr_i,
  input wire logic prop_rd_i,
  input wire logic [15:0] prop_addr_i,
  input wire reiu_pkg::reiu_byte_type prop_wdata_i,
  output reiu_pkg::reiu_byte_type prop_rdata_o,
  output logic prop_ack_o,
  // Status commands
  input wire logic cmd_valid_i,
  input wire reiu_pkg::reiu_byte_type cmd_code_i,
  input wire logic cmd_keep_i,
  output logic cmd_ready_o,
  output logic resp_valid_o,
  output reiu_pkg::reiu_byte_type resp_byte_o,
  output logic resp_last_o,
  // Fast reply
  input wire logic [1:0] frr_sel_i,
  output reiu_pkg::reiu_byte_type fast_reply_bytes_o,
  // Event sources
  input wire reiu_pkg::reiu_byte_type packet_event_i,
  input wire reiu_pkg::reiu_byte_type modem_event_i,
  input wire reiu_pkg::reiu_byte_type chip_event_i,
  input wire reiu_pkg::reiu_byte_type packet_status_i,
  input wire reiu_pkg::reiu_byte_type modem_status_i,
  input wire reiu_pkg::reiu_byte_type chip_status_i,
  input wire logic [STATE_WIDTH-1:0] radio_state_i,
  // Interrupt pin
  output logic event_request_low_o
);
  import reiu_pkg::*;

  localparam int FRR_CYC_INT = `REIU_FRR_DELAY_NS / `REIU_CLK_PERIOD_NS;
  localparam int IRQ_CYC_INT = `REIU_IRQ_DELAY_NS / `REIU_CLK_PERIOD_NS;
  localparam logic [9:0] FRR_CYC = 10'(FRR_CYC_INT);
  localparam logic [9:0] IRQ_CYC = 10'(IRQ_CYC_INT);

  reiu_byte_type event_group_enable_reg;
  reiu_byte_type packet_event_enable_reg;
  reiu_byte_type modem_event_enable_reg;
  reiu_byte_type chip_event_enable_reg;
  reiu_byte_type packet_pend;
  reiu_byte_type modem_pend;
  reiu_byte_type chip_pend;
  reiu_byte_type chip_set;
  reiu_byte_type packet_clr;
  reiu_byte_type modem_clr;
  reiu_byte_type chip_clr;
  reiu_state_type state_reg;
  logic [47:0] resp_shift_reg;
  logic [2:0] resp_left_reg;
  logic [STATE_WIDTH-1:0] state_seen_reg;
  logic [STATE_WIDTH-1:0] frr_state_reg;
  logic [9:0] delay_cnt_reg;
  logic delay_run_reg;
  logic state_event;
  logic irq_reg;
  logic cmd_take;
  logic status_read;
  logic new_enabled;

  // Response length of a command, zero when the code is not a status command
  function automatic logic [2:0] resp_len(input reiu_byte_type code);
    if (code == `REIU_CMD_ALL) begin
      resp_len = `REIU_LEN_ALL;
    end else if (code == `REIU_CMD_PACKET || code == `REIU_CMD_MODEM || code == `REIU_CMD_CHIP) begin
      resp_len = `REIU_LEN_GROUP;
    end else begin
      resp_len = 3'd0;
    end
  endfunction : resp_len

  // Events of one group that may drive the pin
  function automatic reiu_byte_type gated(input reiu_byte_type ev, input reiu_byte_type en, input logic grp);
    gated = grp ? (ev & en) : 8'h00;
  endfunction : gated

  // RULE5 reset enables
  // RULE3 enable bytes
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      event_group_enable_reg <= `REIU_GROUP_EN_RST;
      packet_event_enable_reg <= `REIU_PACKET_EN_RST;
      modem_event_enable_reg <= `REIU_MODEM_EN_RST;
      chip_event_enable_reg <= `REIU_CHIP_EN_RST;
    end else if (prop_wr_i) begin
      if (prop_addr_i == `REIU_PROP_GROUP_EN) begin
        event_group_enable_reg <= prop_wdata_i;
      end else if (prop_addr_i == `REIU_PROP_PACKET_EN) begin
        packet_event_enable_reg <= prop_wdata_i;
      end else if (prop_addr_i == `REIU_PROP_MODEM_EN) begin
        modem_event_enable_reg <= prop_wdata_i;
      end else if (prop_addr_i == `REIU_PROP_CHIP_EN) begin
        chip_event_enable_reg <= prop_wdata_i;
      end
    end
  end

  // Property read data, unmapped numbers read zero
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prop_rdata_o <= 8'h00;
      prop_ack_o <= 1'b0;
    end else begin
      prop_ack_o <= prop_rd_i | prop_wr_i;
      if (prop_rd_i) begin
        if (prop_addr_i == `REIU_PROP_GROUP_EN) begin
          prop_rdata_o <= event_group_enable_reg;
        end else if (prop_addr_i == `REIU_PROP_PACKET_EN) begin
          prop_rdata_o <= packet_event_enable_reg;
        end else if (prop_addr_i == `REIU_PROP_MODEM_EN) begin
          prop_rdata_o <= modem_event_enable_reg;
        end else if (prop_addr_i == `REIU_PROP_CHIP_EN) begin
          prop_rdata_o <= chip_event_enable_reg;
        end else begin
          prop_rdata_o <= 8'h00;
        end
      end
    end
  end

  // RULE12 state change timer
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_seen_reg <= '0;
      frr_state_reg <= '0;
      delay_cnt_reg <= 10'h000;
      delay_run_reg <= 1'b0;
    end else begin
      state_seen_reg <= radio_state_i;
      if (radio_state_i != state_seen_reg) begin
        delay_cnt_reg <= 10'h001;
        delay_run_reg <= 1'b1;
      end else if (delay_run_reg) begin
        delay_cnt_reg <= delay_cnt_reg + 10'h001;
        // Two cycles early: one for this register and one for the fast reply flop
        if (delay_cnt_reg == FRR_CYC - 10'h002) begin
          frr_state_reg <= state_seen_reg;
        end
        if (delay_cnt_reg == IRQ_CYC) begin
          delay_run_reg <= 1'b0;
        end
      end
    end
  end

  // Pin falls one edge after this pulse, so the event is raised one cycle early
  assign state_event = delay_run_reg && (delay_cnt_reg == IRQ_CYC - 10'h001);

  always_comb begin
    chip_set = chip_event_i;
    chip_set[`REIU_CHIP_STATE_BIT] = chip_event_i[`REIU_CHIP_STATE_BIT] | state_event;
  end

  assign cmd_ready_o = (state_reg == REIU_IDLE);
  assign cmd_take = cmd_valid_i && cmd_ready_o && (resp_len(cmd_code_i) != 3'd0);
  assign status_read = cmd_take;

  // RULE6 clear all groups
  // RULE7 clear one group
  // RULE13 clear only what was returned
  always_comb begin
    packet_clr = 8'h00;
    modem_clr = 8'h00;
    chip_clr = 8'h00;
    if (cmd_take && !cmd_keep_i) begin
      if (cmd_code_i == `REIU_CMD_ALL || cmd_code_i == `REIU_CMD_PACKET) begin
        packet_clr = packet_pend;
      end
      if (cmd_code_i == `REIU_CMD_ALL || cmd_code_i == `REIU_CMD_MODEM) begin
        modem_clr = modem_pend;
      end
      if (cmd_code_i == `REIU_CMD_ALL || cmd_code_i == `REIU_CMD_CHIP) begin
        chip_clr = chip_pend;
      end
    end
  end

  reiu_event_group #(.WIDTH(8)) u_packet_group (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .set_i(packet_event_i),
    .clr_i(packet_clr),
    .pend_o(packet_pend)
  );

  reiu_event_group #(.WIDTH(8)) u_modem_group (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .set_i(modem_event_i),
    .clr_i(modem_clr),
    .pend_o(modem_pend)
  );

  reiu_event_group #(.WIDTH(8)) u_chip_group (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .set_i(chip_set),
    .clr_i(chip_clr),
    .pend_o(chip_pend)
  );

  // RULE4 group and event gating
  assign new_enabled =
    |gated(packet_event_i, packet_event_enable_reg, event_group_enable_reg[`REIU_GRP_PACKET_BIT]) ||
    |gated(modem_event_i, modem_event_enable_reg, event_group_enable_reg[`REIU_GRP_MODEM_BIT]) ||
    |gated(chip_set, chip_event_enable_reg, event_group_enable_reg[`REIU_GRP_CHIP_BIT]);

  // RULE1 assert on enabled event
  // RULE2 release on status read
  // RULE13 new event beats the release
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_reg <= 1'b0;
    end else if (new_enabled) begin
      irq_reg <= 1'b1;
    end else if (status_read) begin
      irq_reg <= 1'b0;
    end
  end

  assign event_request_low_o = ~irq_reg;

  // RULE8 pending bytes then live status
  // RULE9 live status ignores enables
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= REIU_IDLE;
      resp_shift_reg <= 48'h0000_0000_0000;
      resp_left_reg <= 3'd0;
      resp_valid_o <= 1'b0;
      resp_byte_o <= 8'h00;
      resp_last_o <= 1'b0;
    end else begin
      case (state_reg)
        REIU_IDLE: begin
          resp_valid_o <= 1'b0;
          resp_last_o <= 1'b0;
          if (cmd_take) begin
            resp_left_reg <= resp_len(cmd_code_i);
            state_reg <= REIU_SEND;
            if (cmd_code_i == `REIU_CMD_ALL) begin
              resp_shift_reg <= {chip_status_i, modem_status_i, packet_status_i, chip_pend, modem_pend, packet_pend};
            end else if (cmd_code_i == `REIU_CMD_PACKET) begin
              resp_shift_reg <= {32'h0000_0000, packet_status_i, packet_pend};
            end else if (cmd_code_i == `REIU_CMD_MODEM) begin
              resp_shift_reg <= {32'h0000_0000, modem_status_i, modem_pend};
            end else begin
              resp_shift_reg <= {32'h0000_0000, chip_status_i, chip_pend};
            end
          end
        end
        REIU_SEND: begin
          resp_valid_o <= 1'b1;
          resp_byte_o <= resp_shift_reg[7:0];
          resp_shift_reg <= {8'h00, resp_shift_reg[47:8]};
          resp_left_reg <= resp_left_reg - 3'd1;
          resp_last_o <= (resp_left_reg == 3'd1);
          if (resp_left_reg == 3'd1) begin
            state_reg <= REIU_IDLE;
          end
        end
        default: begin
          state_reg <= REIU_IDLE;
        end
      endcase
    end
  end

  // RULE10 fast reply never clears
  // RULE12 delayed state in fast reply
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fast_reply_bytes_o <= 8'h00;
    end else if (frr_sel_i == `REIU_FRR_PACKET) begin
      fast_reply_bytes_o <= packet_pend;
    end else if (frr_sel_i == `REIU_FRR_MODEM) begin
      fast_reply_bytes_o <= modem_pend;
    end else if (frr_sel_i == `REIU_FRR_CHIP) begin
      fast_reply_bytes_o <= chip_pend;
    end else begin
      fast_reply_bytes_o <= 8'(frr_state_reg);
    end
  end

endmodule : radio_event_interrupt_unit

// ---- radio_event_interrupt_unit_props.sv ----
// Port checker of the radio event interrupt unit
`timescale 1ns/1ns
`include "reiu_consts.svh"
module reiu_props #(
  parameter int STATE_WIDTH = 4
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Requests
  input wire logic prop_wr_i,
  input wire logic prop_rd_i,
  input wire logic cmd_valid_i,
  input wire reiu_pkg::reiu_byte_type cmd_code_i,
  input wire reiu_pkg::reiu_byte_type packet_event_i,
  input wire reiu_pkg::reiu_byte_type modem_event_i,
  input wire reiu_pkg::reiu_byte_type chip_event_i,
  input wire logic [STATE_WIDTH-1:0] radio_state_i,
  // Answers
  input wire logic prop_ack_o,
  input wire logic cmd_ready_o,
  input wire logic resp_valid_o,
  input wire logic resp_last_o,
  input wire logic event_request_low_o
);
  import reiu_pkg::*;
  logic [STATE_WIDTH-1:0] state_reg;
  logic [9:0] since_reg;
  logic take, ev, near;
  assign take = cmd_valid_i && cmd_ready_o && cmd_code_i >= `REIU_CMD_ALL && cmd_code_i <= `REIU_CMD_CHIP;
  assign ev = |{packet_event_i, modem_event_i, chip_event_i};
  // State-change event is due about 325 cycles on; allow slack around it
  assign near = since_reg >= 10'h13e && since_reg <= 10'h14c;
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= '0;
      since_reg <= 10'h3ff;
    end else begin
      state_reg <= radio_state_i;
      if (radio_state_i != state_reg) since_reg <= 10'h001;
      else if (since_reg != 10'h3ff) since_reg <= since_reg + 10'h001;
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  ack_after_strobe_a: assert property ((prop_wr_i || prop_rd_i) |=> prop_ack_o)
    else $error("no ack after property strobe");
  ack_only_strobe_a: assert property (!(prop_wr_i || prop_rd_i) |=> !prop_ack_o)
    else $error("ack without property strobe");
  pin_cause_a: assert property ($fell(event_request_low_o) |-> $past(ev) || near)
    else $error("pin fell without event");
  pin_hold_a: assert property (!event_request_low_o && !take |=> !event_request_low_o)
    else $error("pin released without status command");
  pin_release_a: assert property (take && !ev && !near |=> event_request_low_o)
    else $error("pin not released by status command");
  reply_start_a: assert property (take |=> !cmd_ready_o ##1 resp_valid_o)
    else $error("reply not started two cycles after take");
  all_length_a: assert property (take && cmd_code_i == `REIU_CMD_ALL |->
    ##2 (resp_valid_o && !resp_last_o)[*5] ##1 (resp_valid_o && resp_last_o)) else $error("combined reply length");
  group_length_a: assert property (take && cmd_code_i != `REIU_CMD_ALL |->
    ##2 (resp_valid_o && !resp_last_o) ##1 (resp_valid_o && resp_last_o) ##1 !resp_valid_o)
    else $error("group reply length");
endmodule : reiu_props

bind radio_event_interrupt_unit reiu_props #(.STATE_WIDTH(STATE_WIDTH)) props_i (.sys_clk_i, .rst_i, .prop_wr_i,
  .prop_rd_i, .cmd_valid_i, .cmd_code_i, .packet_event_i, .modem_event_i, .chip_event_i, .radio_state_i,
  .prop_ack_o, .cmd_ready_o, .resp_valid_o, .resp_last_o, .event_request_low_o);

// ---- reiu_host.sv ----
// Host controller model issuing property and status command requests
`timescale 1ns/1ns
module reiu_host (
  // Clock and answers
  input wire logic sys_clk_i,
  input wire logic cmd_ready_i,
  input wire logic resp_last_i,
  // Requests
  output logic prop_wr_o,
  output logic prop_rd_o,
  output logic [15:0] prop_addr_o,
  output reiu_pkg::reiu_byte_type prop_wdata_o,
  output logic cmd_valid_o,
  output reiu_pkg::reiu_byte_type cmd_code_o,
  output logic cmd_keep_o
);
  import reiu_pkg::*;
  initial {prop_wr_o, prop_rd_o, prop_addr_o, prop_wdata_o, cmd_valid_o, cmd_code_o, cmd_keep_o} = '0;
  task automatic prop(input logic wr, input logic [15:0] addr, input reiu_byte_type data);
    @(posedge sys_clk_i);
    prop_wr_o <= wr;
    prop_rd_o <= !wr;
    prop_addr_o <= addr;
    prop_wdata_o <= data;
    @(posedge sys_clk_i);
    prop_wr_o <= 1'b0;
    prop_rd_o <= 1'b0;
    prop_addr_o <= ~addr;
    prop_wdata_o <= ~data;
    @(posedge sys_clk_i);
  endtask : prop
  task automatic cmd(input reiu_byte_type code, input logic keep);
    @(posedge sys_clk_i);
    cmd_valid_o <= 1'b1;
    cmd_code_o <= code;
    cmd_keep_o <= keep;
    do @(posedge sys_clk_i); while (!cmd_ready_i);
    cmd_valid_o <= 1'b0;
    cmd_code_o <= ~code;
    do @(posedge sys_clk_i); while (!resp_last_i);
  endtask : cmd
endmodule : reiu_host

// ---- radio_event_interrupt_unit_tb_top.sv ----
// Self-checking bench of the radio event interrupt unit
`timescale 1ns/1ns
`include "reiu_consts.svh"
module radio_event_interrupt_unit_tb_top;
  import reiu_pkg::*;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic prop_wr, prop_rd, keep, valid, ack, ready, rvalid, last, pin;
  logic rd_d = 1'b0;
  logic [15:0] addr;
  logic [1:0] frr_sel = 2'h0;
  logic [3:0] state = 4'h0;
  reiu_byte_type wdata, rdata, code, resp, fast_reply_bytes;
  reiu_byte_type ev[3] = '{default: 8'h00};
  reiu_byte_type st[3], v[3];
  reiu_byte_type exp_q[$], rd_q[$];
  int num_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  always #20 sys_clk_i = ~sys_clk_i;
  radio_event_interrupt_unit #(.STATE_WIDTH(4)) DUT (.sys_clk_i, .rst_i, .prop_wr_i(prop_wr), .prop_rd_i(prop_rd),
    .prop_addr_i(addr), .prop_wdata_i(wdata), .prop_rdata_o(rdata), .prop_ack_o(ack), .cmd_valid_i(valid),
    .cmd_code_i(code), .cmd_keep_i(keep), .cmd_ready_o(ready), .resp_valid_o(rvalid), .resp_byte_o(resp),
    .resp_last_o(last), .frr_sel_i(frr_sel), .fast_reply_bytes_o(fast_reply_bytes), .packet_event_i(ev[0]),
    .modem_event_i(ev[1]), .chip_event_i(ev[2]), .packet_status_i(st[0]), .modem_status_i(st[1]),
    .chip_status_i(st[2]), .radio_state_i(state), .event_request_low_o(pin));
  reiu_host host (.sys_clk_i, .cmd_ready_i(ready), .resp_last_i(last), .prop_wr_o(prop_wr), .prop_rd_o(prop_rd),
    .prop_addr_o(addr), .prop_wdata_o(wdata), .cmd_valid_o(valid), .cmd_code_o(code), .cmd_keep_o(keep));
  task automatic check(input string name, input reiu_byte_type exp, input reiu_byte_type got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic complete_run;
    if (num_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task automatic pulse(input int g, input reiu_byte_type val);
    @(posedge sys_clk_i);
    ev[g] <= val;
    @(posedge sys_clk_i);
    ev[g] <= 8'h00;
  endtask : pulse
  task automatic pin_is(input logic lvl);
    @(negedge sys_clk_i);
    check("pin", {7'h00, lvl}, {7'h00, pin});
  endtask : pin_is
  task automatic frr_is(input logic [1:0] s, input reiu_byte_type e);
    @(posedge sys_clk_i);
    frr_sel <= s;
    @(posedge sys_clk_i);
    @(negedge sys_clk_i);
    check("fast", e, fast_reply_bytes);
  endtask : frr_is
  task automatic all6(input reiu_byte_type p, input reiu_byte_type m, input reiu_byte_type c);
    exp_q = {exp_q, p, m, c, st[0], st[1], st[2]};
  endtask : all6
  // Result watcher and hang guard
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      complete_run();
    end else begin
      if (rvalid) check("reply", exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx, resp);
      if (ack && rd_d) check("prop", rd_q.size() > 0 ? rd_q.pop_front() : 8'hxx, rdata);
      rd_d = prop_rd;
    end
  end
  initial begin
    int g;
    reiu_byte_type w;
    void'($urandom(35));
    foreach (st[i]) st[i] <= 8'($urandom);
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    rd_q = '{8'h04, 8'h00, 8'h00, 8'h04, 8'h00, 8'h07};
    for (g = 0; g < 5; g++) host.prop(1'b0, 16'h0100 + 16'(g), 8'h00);
    host.prop(1'b1, `REIU_PROP_GROUP_EN, 8'h07);
    for (g = 1; g < 4; g++) host.prop(1'b1, 16'h0100 + 16'(g), 8'hff);
    host.prop(1'b0, `REIU_PROP_GROUP_EN, 8'h00);
    for (g = 0; g < 3; g++) begin
      v[g] = 8'($urandom_range(1, 255));
      pulse(g, v[g]);
      pin_is(1'b0);
      frr_is(2'(g), v[g]);
      pin_is(1'b0);
      exp_q = {exp_q, v[g], st[g]};
      host.cmd(`REIU_CMD_PACKET + 8'(g), 1'b0);
      pin_is(1'b1);
      frr_is(2'(g), 8'h00);
    end
    foreach (v[i]) v[i] = 8'($urandom_range(1, 255));
    w = 8'($urandom_range(1, 255));
    fork pulse(0, v[0]); pulse(1, v[1]); pulse(2, v[2]); join
    exp_q = {exp_q, v[1], st[1]};
    host.cmd(`REIU_CMD_MODEM, 1'b0);
    pin_is(1'b1);
    all6(v[0], 8'h00, v[2]);
    host.cmd(`REIU_CMD_ALL, 1'b1);
    all6(v[0], 8'h00, v[2]);
    fork host.cmd(`REIU_CMD_ALL, 1'b0); pulse(0, w); join
    pin_is(1'b0);
    all6(w, 8'h00, 8'h00);
    host.cmd(`REIU_CMD_ALL, 1'b0);
    host.prop(1'b1, `REIU_PROP_GROUP_EN, 8'h03);
    host.prop(1'b1, `REIU_PROP_MODEM_EN, 8'h00);
    @(posedge sys_clk_i);
    foreach (st[i]) st[i] <= 8'($urandom);
    fork pulse(1, v[1]); pulse(2, v[2]); join
    pin_is(1'b1);
    all6(8'h00, v[1], v[2]);
    host.cmd(`REIU_CMD_ALL, 1'b0);
    host.prop(1'b1, `REIU_PROP_GROUP_EN, 8'h07);
    host.prop(1'b1, `REIU_PROP_CHIP_EN, 8'h10);
    @(posedge sys_clk_i);
    frr_sel <= `REIU_FRR_STATE;
    state <= 4'h9;
    // Edges counted from the one that launched the new state: 125 for fast reply, 325 for the pin
    repeat (124) @(posedge sys_clk_i);
    @(negedge sys_clk_i) check("fast", 8'h00, fast_reply_bytes);
    @(posedge sys_clk_i);
    @(negedge sys_clk_i) check("fast", 8'h09, fast_reply_bytes);
    repeat (199) @(posedge sys_clk_i);
    pin_is(1'b1);
    @(posedge sys_clk_i);
    pin_is(1'b0);
    exp_q = {exp_q, 8'h10, st[2]};
    host.cmd(`REIU_CMD_CHIP, 1'b0);
    pin_is(1'b1);
    // Notes still queued mean a reply byte or a property answer never came
    check("reply queue", 8'h00, 8'(exp_q.size()));
    check("prop queue", 8'h00, 8'(rd_q.size()));
    complete_run();
  end
endmodule : radio_event_interrupt_unit_tb_top
